//--- rtl/cmd_port_pkg.sv
// Shared constants and carrier types of the host input command port
package cmd_port_pkg;
	localparam logic [2:0] CTRL_OFS = 3'h0;
	localparam logic [2:0] LOW_OFS = 3'h4;
	localparam logic [2:0] HIGH_OFS = 3'h6;
	localparam int DIR_BIT = 2;
	localparam int REQUEST_BIT = 5;
	localparam int IENABLE_BIT = 6;
	localparam int READY_BIT = 7;
	localparam int SOFT_RESET_BIT = 14;
	localparam int RUN_BIT = 15;
	localparam int RESUME_BIT = 12;
	localparam int HALF_DUPLEX_BIT = 10;
	localparam int MAINT_BIT = 8;
	localparam int COUNT_MSB = 13;
	localparam logic [1:0] CMD_TABLE = 2'h3;
	localparam logic [1:0] CMD_CONTROL = 2'h1;
	localparam logic [1:0] CMD_BUFFER = 2'h0;
	localparam logic [15:0] PROC_ERR_CODE = 16'h0200;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [17:0] DUMP_BASE = 18'h00000;
	localparam logic [7:0] COPY_WORDS = 8'h40;
	localparam logic [7:0] DUMP_WORDS = 8'h80;
	localparam int MEM_WORDS = 128;
	localparam int CLK_PERIOD_NS = 20;
	localparam int INIT_TIME_NS = 2000;
	localparam int INIT_CYCLES_I = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] INIT_CYCLES = INIT_CYCLES_I[7:0];

	typedef struct packed {
		logic write;
		logic read;
		logic [2:0] addr;
		logic [1:0] byteEn;
		logic [15:0] wdata;
	} hostAccess_t;

	typedef struct packed {
		logic req;
		logic write;
		logic [17:0] addr;
		logic [15:0] wdata;
	} memBus_t;

	typedef struct packed {
		logic rxDir;
		logic [17:0] addr;
		logic [13:0] count;
	} bufInfo_t;
endpackage

//--- rtl/block_mover.sv
// Word mover between host memory and the internal protocol memory
`timescale 1ns/10ps
`default_nettype none
module block_mover
	import cmd_port_pkg::*;
(
	input wire logic clk,
	input wire logic clr,
	input wire logic start,
	input wire logic dumpMode,
	input wire logic [17:0] baseAddr,
	input wire logic [7:0] wordCount,
	output logic done_q,
	output var memBus_t memBus_q,
	input wire logic memAck,
	input wire logic [15:0] memRdata
);
	logic [15:0] mem [MEM_WORDS];
	logic [7:0] idx_q;
	logic [7:0] last_q;
	logic dump_q;
	logic [6:0] slot;

	assign slot = idx_q[6:0];

	// ----------------------------------------
	// Transfer sequencing
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			memBus_q <= '0;
			idx_q <= 8'h00;
			last_q <= 8'h00;
			dump_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (start && !memBus_q.req)
			begin
				idx_q <= 8'h00;
				last_q <= wordCount - 8'h01;
				dump_q <= dumpMode;
				memBus_q.req <= 1'b1;
				memBus_q.write <= dumpMode;
				memBus_q.addr <= baseAddr;
				memBus_q.wdata <= mem[0];
			end
			else if (memBus_q.req && memAck)
			begin
				if (idx_q == last_q)
				begin
					memBus_q.req <= 1'b0;
					done_q <= 1'b1;
				end
				else
				begin
					idx_q <= idx_q + 8'h01;
					memBus_q.addr <= memBus_q.addr + 18'h00002;
					memBus_q.wdata <= mem[slot + 7'h01];
				end
			end
		end
	end

	// Storage keeps its contents over a clear so a resumed table survives
	always_ff @(posedge clk)
	begin
		if (memBus_q.req && memAck && !dump_q)
			mem[slot] <= memRdata;
	end
endmodule
`default_nettype wire

//--- rtl/host_input_command_port.sv
// Host input command port: control word, data port, handshake, command decode
//
// Overview of operation
// [RL1] Whole-word control writes keep run bit set
// [RL2] Host waits for ready drop before requesting
// [RL3] Initialized state: line idle, watch maintenance
// [RL4] Only table assign accepted when initialized
// [RL5] Procedure error dumps memory to host low core
// [RL6] Soft reset bit master-clears, clears itself
// [RL7] Host waits two microseconds after clear
// [RL8] Run bit set when initialization finishes
// [RL9] Bits 1:0 select table, control, buffer
// [RL10] Bit 5 requests, bit 6 enables interrupt
// [RL11] Ready set when port free and requested
// [RL12] Request drop: device reads port, clears ready
// [RL13] Host keeps interrupt enable while awaiting ready
// [RL14] Assigned table owned until next clear
// [RL15] Resume clear starts link protocol start-up
// [RL16] Resume set copies table into memory
// [RL17] Control setup: duplex bit 10, maintenance 8
// [RL18] Buffer before table and control is error
// [RL19] Control bit 2 selects receive buffer
// [RL20] Buffer address 18 bits, count 14 bits
// [RL21] At most seven buffers per direction outstanding
// [RL22] Buffer holds one message, 1..16383 bytes
// [RL23] Procedure error reports code at bit 9
`timescale 1ns/10ps
`default_nettype none
module host_input_command_port
	import cmd_port_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic hostInitPin,
	input wire hostAccess_t hostAcc,
	output logic [15:0] regRdata_q,
	output var memBus_t memBus,
	input wire logic memAck,
	input wire logic [15:0] memRdata,
	output logic lineActive_q,
	output logic maintMonitor_q,
	output logic startupReq_q,
	output logic resumed_q,
	output logic halfDuplex_q,
	output logic maintMode_q,
	output logic [17:0] tableBase_q,
	output logic bufValid_q,
	output var bufInfo_t bufInfo_q,
	output logic procError_q,
	output logic [15:0] errorCode_q
);
	typedef enum logic [6:0] {
		ST_BOOT = 7'h01, ST_IDLE = 7'h02, ST_READY = 7'h04, ST_EXEC = 7'h08,
		ST_COPY = 7'h10, ST_DUMP = 7'h20, ST_HALT = 7'h40
	} portState_t;

	portState_t state_q;
	logic init1_q, init2_q, softClear_q, clr, run_q, ready_q, dir_q, request_q, ienable_q;
	logic exDir_q, tableOk_q, controlOk_q, badCmd, ctrlHit, lowHit, highHit;
	logic moverStart, moverDump, moverDone;
	logic [1:0] cmd_q, exCmd_q;
	logic [7:0] bootCnt_q;
	logic [15:0] dataLow_q, dataHigh_q, exLow_q, exHigh_q, ctrlWord;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] mergeBytes(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be);
		mergeBytes = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Two high bits of the upper word extend the low word to an 18-bit address
	function automatic logic [17:0] hostAddr(input logic [15:0] lo, input logic [15:0] hi);
		hostAddr = {hi[15:14], lo};
	endfunction

	// ----------------------------------------
	// Clear sources
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			init1_q <= 1'b0;
			init2_q <= 1'b0;
			softClear_q <= 1'b0;
		end
		else
		begin
			init1_q <= hostInitPin;
			init2_q <= init1_q;
			// One-cycle pulse; the bit never needs to be written back to zero
			softClear_q <= ctrlHit && hostAcc.byteEn[1]
				&& hostAcc.wdata[SOFT_RESET_BIT] && !softClear_q; // [RL6]
		end
	end

	assign ctrlHit = hostAcc.write && hostAcc.addr == CTRL_OFS;
	assign lowHit = hostAcc.write && hostAcc.addr == LOW_OFS;
	assign highHit = hostAcc.write && hostAcc.addr == HIGH_OFS;

	assign clr = reset || softClear_q || init2_q; // [RL6] [RL8]

	// ----------------------------------------
	// Host-written control and data port
	// ----------------------------------------
	// Run bit is device-owned, so a whole-word write with it clear does not stop the port
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			cmd_q <= CTRL_RESET[1:0];
			dir_q <= 1'b0;
			request_q <= 1'b0;
			ienable_q <= 1'b0;
		end
		else if (ctrlHit && hostAcc.byteEn[0])
		begin
			cmd_q <= hostAcc.wdata[1:0]; // [RL9]
			dir_q <= hostAcc.wdata[DIR_BIT]; // [RL19]
			request_q <= hostAcc.wdata[REQUEST_BIT]; // [RL10]
			ienable_q <= hostAcc.wdata[IENABLE_BIT]; // [RL10]
		end
	end

	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			dataLow_q <= 16'h0000;
			dataHigh_q <= 16'h0000;
		end
		else
		begin
			if (lowHit)
				dataLow_q <= mergeBytes(dataLow_q, hostAcc.wdata, hostAcc.byteEn);
			if (highHit)
				dataHigh_q <= mergeBytes(dataHigh_q, hostAcc.wdata, hostAcc.byteEn);
		end
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	always_comb
	begin
		ctrlWord = 16'h0000;
		ctrlWord[1:0] = cmd_q;
		ctrlWord[DIR_BIT] = dir_q;
		ctrlWord[REQUEST_BIT] = request_q;
		ctrlWord[IENABLE_BIT] = ienable_q;
		ctrlWord[READY_BIT] = ready_q;
		ctrlWord[RUN_BIT] = run_q;
	end

	always_ff @(posedge clk)
	begin
		if (clr)
			regRdata_q <= 16'h0000;
		else if (hostAcc.read)
		begin
			unique case (hostAcc.addr)
				CTRL_OFS: regRdata_q <= ctrlWord;
				LOW_OFS: regRdata_q <= dataLow_q;
				HIGH_OFS: regRdata_q <= dataHigh_q;
				default: regRdata_q <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	always_comb
	begin
		unique case (exCmd_q)
			CMD_TABLE: badCmd = tableOk_q; // [RL23]
			CMD_CONTROL: badCmd = !tableOk_q; // [RL4] [RL23]
			CMD_BUFFER: badCmd = !(tableOk_q && controlOk_q); // [RL18]
			default: badCmd = 1'b1; // [RL23]
		endcase
	end

	// ----------------------------------------
	// Port sequencer
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			state_q <= ST_BOOT;
			bootCnt_q <= INIT_CYCLES;
			run_q <= 1'b0;
			ready_q <= 1'b0;
			exCmd_q <= CMD_BUFFER;
			exDir_q <= 1'b0;
			exLow_q <= 16'h0000;
			exHigh_q <= 16'h0000;
		end
		else
		begin
			unique case (state_q)
				ST_BOOT:
				begin
					bootCnt_q <= bootCnt_q - 8'h01;
					if (bootCnt_q == 8'h01)
					begin
						run_q <= 1'b1; // [RL8]
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE:
					if (request_q)
					begin
						ready_q <= 1'b1; // [RL11]
						state_q <= ST_READY;
					end
				ST_READY:
					if (!request_q)
					begin
						exCmd_q <= cmd_q; // [RL12]
						exDir_q <= dir_q;
						exLow_q <= dataLow_q;
						exHigh_q <= dataHigh_q;
						ready_q <= 1'b0; // [RL12]
						state_q <= ST_EXEC;
					end
				ST_EXEC:
					if (badCmd)
						state_q <= ST_DUMP; // [RL5]
					else if (exCmd_q == CMD_TABLE && exHigh_q[RESUME_BIT])
						state_q <= ST_COPY; // [RL16]
					else
						state_q <= ST_IDLE;
				ST_COPY:
					if (moverDone)
						state_q <= ST_IDLE;
				ST_DUMP:
					if (moverDone)
						state_q <= ST_HALT;
				ST_HALT:
					state_q <= ST_HALT;
			endcase
		end
	end

	assign moverStart = state_q == ST_EXEC && (badCmd || (exCmd_q == CMD_TABLE
		&& exHigh_q[RESUME_BIT]));
	assign moverDump = badCmd;

	// ----------------------------------------
	// Command effects
	// ----------------------------------------
	// Table stays owned until the next clear; a second assign is refused
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			tableOk_q <= 1'b0;
			controlOk_q <= 1'b0;
			tableBase_q <= 18'h00000;
			halfDuplex_q <= 1'b0;
			maintMode_q <= 1'b0;
			startupReq_q <= 1'b0;
			resumed_q <= 1'b0;
			bufValid_q <= 1'b0;
			bufInfo_q <= '0;
			procError_q <= 1'b0;
			errorCode_q <= 16'h0000;
		end
		else
		begin
			startupReq_q <= 1'b0;
			bufValid_q <= 1'b0;
			if (state_q == ST_EXEC && badCmd)
			begin
				procError_q <= 1'b1; // [RL23]
				errorCode_q <= PROC_ERR_CODE; // [RL23]
			end
			else if (state_q == ST_EXEC)
			begin
				unique case (exCmd_q)
					CMD_TABLE:
					begin
						tableOk_q <= 1'b1; // [RL14]
						tableBase_q <= hostAddr(exLow_q, exHigh_q);
						startupReq_q <= !exHigh_q[RESUME_BIT]; // [RL15]
						resumed_q <= exHigh_q[RESUME_BIT]; // [RL16]
					end
					CMD_CONTROL:
					begin
						controlOk_q <= 1'b1;
						halfDuplex_q <= exHigh_q[HALF_DUPLEX_BIT]; // [RL17]
						maintMode_q <= exHigh_q[MAINT_BIT]; // [RL17]
					end
					default:
					begin
						bufValid_q <= 1'b1; // [RL20]
						bufInfo_q.rxDir <= exDir_q; // [RL19]
						bufInfo_q.addr <= hostAddr(exLow_q, exHigh_q); // [RL20]
						bufInfo_q.count <= exHigh_q[COUNT_MSB:0]; // [RL20] [RL22]
					end
				endcase
			end
		end
	end

	// Line stays silent until set up; a procedure error stops it until the next clear
	always_ff @(posedge clk)
	begin
		if (clr)
		begin
			lineActive_q <= 1'b0;
			maintMonitor_q <= 1'b0;
		end
		else
		begin
			lineActive_q <= tableOk_q && controlOk_q && !procError_q; // [RL3]
			maintMonitor_q <= run_q && !tableOk_q; // [RL3]
		end
	end

	block_mover mover (
		.clk(clk), .clr(clr), .start(moverStart), .dumpMode(moverDump),
		.baseAddr(moverDump ? DUMP_BASE : hostAddr(exLow_q, exHigh_q)), // [RL5]
		.wordCount(moverDump ? DUMP_WORDS : COPY_WORDS), // [RL5] [RL16]
		.done_q(moverDone), .memBus_q(memBus), .memAck(memAck), .memRdata(memRdata)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (clr);

	sequence reqSeen;
		state_q == ST_IDLE && request_q;
	endsequence
	sequence handOver;
		state_q == ST_READY && !request_q;
	endsequence
	chk_ready_sets: assert property (reqSeen |=> ready_q && state_q == ST_READY) // [RL11]
		else $error("ready flag not set on request");
	chk_ready_drop: assert property (handOver |=> !ready_q ##1 state_q != ST_READY) // [RL12]
		else $error("ready flag not cleared after request drop");
	chk_soft_clear: assert property (@(posedge clk) disable iff (reset) // [RL6]
		softClear_q |=> !softClear_q ##1 !run_q)
		else $error("soft reset bit did not self clear");
	chk_run_boot: assert property (state_q == ST_BOOT && bootCnt_q == 8'h01 |=> run_q) // [RL8]
		else $error("run bit not set at end of init");
	chk_quiet_init: assert property (!tableOk_q |=> !lineActive_q) // [RL3]
		else $error("line active before setup");
	chk_error_code: assert property (state_q == ST_EXEC && badCmd // [RL4] [RL23]
		|=> procError_q && errorCode_q == PROC_ERR_CODE && state_q == ST_DUMP)
		else $error("procedure error not reported");
	chk_dump_target: assert property (state_q == ST_EXEC && badCmd // [RL5]
		|=> ##1 memBus.req && memBus.write && memBus.addr == DUMP_BASE)
		else $error("dump did not start at host address zero");
	chk_resume_copy: assert property (state_q == ST_EXEC && !badCmd // [RL15] [RL16]
		&& exCmd_q == CMD_TABLE
		|=> (exHigh_q[RESUME_BIT] ? state_q == ST_COPY : startupReq_q))
		else $error("table assign resume handling wrong");
	chk_buf_order: assert property (bufValid_q |-> tableOk_q && controlOk_q) // [RL18]
		else $error("buffer accepted before setup");
endmodule
`default_nettype wire

//--- dv/host_memory_model.sv
// Host memory model answering the command port's memory master
`timescale 1ns/10ps
`default_nettype none
module host_memory_model
	import cmd_port_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic slow,
	input wire memBus_t memBus,
	output var logic memAck,
	output logic [15:0] memRdata,
	output var int readCount,
	output var int writeCount,
	output var logic [17:0] lastWriteAddr,
	output var logic [15:0] word0Data
);
	logic [1:0] waitCnt;
	logic [15:0] lastData;
	// Data is valid only with the ack; otherwise it shows the inverse
	assign memRdata = memAck ? lastData : ~lastData;
	// Table words are only read, never altered here
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			memAck <= 1'b0;
			waitCnt <= 2'h0;
			readCount <= 0;
			writeCount <= 0;
			lastWriteAddr <= 18'h00000;
			word0Data <= 16'h0000;
			lastData <= 16'h0000;
		end
		else if (memAck)
			memAck <= 1'b0;
		else if (memBus.req)
		begin
			if (slow && waitCnt != 2'h3)
				waitCnt <= waitCnt + 2'h1;
			else
			begin
				waitCnt <= 2'h0;
				memAck <= 1'b1;
				lastData <= memBus.addr[15:0] ^ 16'h5a5a;
				if (memBus.write)
				begin
					writeCount <= writeCount + 1;
					lastWriteAddr <= memBus.addr;
					if (memBus.addr == 18'h00000)
						word0Data <= memBus.wdata;
				end
				else
					readCount <= readCount + 1;
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/test_host_input_command_port.sv
// Self-checking bench of the host input command port
`timescale 1ns/10ps
`default_nettype none
module test_host_input_command_port;
	import cmd_port_pkg::*;
	typedef struct packed {
		logic [1:0] code;
		logic dir;
		logic ien;
		logic [15:0] lo;
		logic [15:0] hi;
	} row_t;
	logic clk, reset, hostInitPin, slow, memAck, lineActive_q, maintMonitor_q;
	logic startupReq_q, resumed_q, halfDuplex_q, maintMode_q, bufValid_q, procError_q;
	logic [15:0] regRdata_q, memRdata, errorCode_q, word0Data;
	logic [17:0] tableBase_q, lastWriteAddr;
	hostAccess_t hostAcc;
	memBus_t memBus;
	bufInfo_t bufInfo_q, lastInfo;
	int readCount, writeCount, miscompares = 0, checkCount = 0, startupSeen = 0, bufSeen = 0;
	// Two buffers at most outstanding, counts within 1..16383
	row_t rows [4] = '{'{CMD_TABLE, 1'b0, 1'b1, 16'h1000, 16'h4000},
		'{CMD_CONTROL, 1'b0, 1'b0, 16'h0000, 16'h0500},
		'{CMD_BUFFER, 1'b0, 1'b1, 16'h2000, 16'h0001},
		'{CMD_BUFFER, 1'b1, 1'b0, 16'hfffe, 16'hffff}};
	host_input_command_port host_input_command_port_inst (.clk(clk), .reset(reset),
		.hostInitPin(hostInitPin), .hostAcc(hostAcc), .regRdata_q(regRdata_q),
		.memBus(memBus), .memAck(memAck), .memRdata(memRdata),
		.lineActive_q(lineActive_q), .maintMonitor_q(maintMonitor_q),
		.startupReq_q(startupReq_q), .resumed_q(resumed_q), .halfDuplex_q(halfDuplex_q),
		.maintMode_q(maintMode_q), .tableBase_q(tableBase_q), .bufValid_q(bufValid_q),
		.bufInfo_q(bufInfo_q), .procError_q(procError_q), .errorCode_q(errorCode_q));
	host_memory_model host_memory_model_inst (.clk(clk), .reset(reset), .slow(slow),
		.memBus(memBus), .memAck(memAck), .memRdata(memRdata), .readCount(readCount),
		.writeCount(writeCount), .lastWriteAddr(lastWriteAddr), .word0Data(word0Data));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// One-cycle pulses are caught here so that no poll can miss them
	always @(posedge clk)
	begin
		if (startupReq_q === 1'b1)
			startupSeen++;
		if (bufValid_q === 1'b1)
		begin
			bufSeen++;
			lastInfo = bufInfo_q;
		end
	end
	task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Control writes use single byte lanes only; the run bit is written as zero only by the soft clear's high-byte write
	task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge clk);
		hostAcc <= {1'b1, 1'b0, a, be, d};
		@(posedge clk);
		hostAcc <= '0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge clk);
		hostAcc <= {1'b0, 1'b1, a, 2'h0, 16'h0000};
		@(posedge clk);
		hostAcc <= '0;
		@(posedge clk);
		#1 v = regRdata_q;
	endtask
	task automatic cmd(input row_t r, output logic ok);
		logic [15:0] v;
		int n;
		ok = 1'b0;
		wr(CTRL_OFS, 2'h1, {8'h00, 1'b0, r.ien, 1'b1, 2'h0, r.dir, r.code});
		for (n = 0; n < 20 && !ok; n++)
		begin
			rd(CTRL_OFS, v);
			ok = (v[READY_BIT] === 1'b1);
		end
		if (!ok)
			return;
		check("ienable", v[IENABLE_BIT], r.ien);
		wr(LOW_OFS, 2'h3, r.lo);
		wr(HIGH_OFS, 2'h3, r.hi);
		// Interrupt enable is kept as it was while the request drops
		wr(CTRL_OFS, 2'h1, {8'h00, 1'b0, r.ien, 1'b0, 2'h0, r.dir, r.code});
		for (n = 0; n < 20 && v[READY_BIT] !== 1'b0; n++)
			rd(CTRL_OFS, v);
		check("ready drop", v[READY_BIT], 1'b0);
		repeat (3) @(posedge clk);
	endtask
	task automatic waitRun();
		logic [15:0] v;
		int n;
		v = 16'h0000;
		for (n = 0; n < 150 && v[RUN_BIT] !== 1'b1; n++)
			rd(CTRL_OFS, v);
		check("run", v[RUN_BIT], 1'b1);
		check("clear bit", v[SOFT_RESET_BIT], 1'b0);
	endtask
	task automatic clearPort(input logic viaPin);
		if (viaPin)
		begin
			@(posedge clk);
			hostInitPin <= 1'b1;
			repeat (3) @(posedge clk);
			hostInitPin <= 1'b0;
		end
		else
			wr(CTRL_OFS, 2'h2, 16'h4000);
		repeat (100) @(posedge clk);
		waitRun();
	endtask
	task automatic waitCount(ref int cnt, input int target);
		for (int n = 0; n < 3000 && cnt < target; n++)
			@(posedge clk);
		repeat (20) @(posedge clk);
	endtask
	initial
	begin
		repeat (40000) @(posedge clk);
		miscompares++;
		reportAndStop();
	end
	initial
	begin
		logic [15:0] v;
		logic ok;
		int s0, b0, c0;
		row_t r;
		reset = 1'b1;
		hostInitPin = 1'b0;
		hostAcc = '0;
		slow = 1'b0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		rd(CTRL_OFS, v);
		check("ctrl at reset", v, CTRL_RESET);
		waitRun();
		check("monitor", maintMonitor_q, 1'b1);
		check("line idle", lineActive_q, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			r = rows[i];
			s0 = startupSeen;
			b0 = bufSeen;
			cmd(r, ok);
			check("ready", ok, 1'b1);
			check("no error", procError_q, 1'b0);
			case (r.code)
				CMD_TABLE:
				begin
					check("base", tableBase_q, {r.hi[15:14], r.lo});
					check("startup", startupSeen - s0, 1);
					check("monitor off", maintMonitor_q, 1'b0);
				end
				CMD_CONTROL:
				begin
					check("duplex", halfDuplex_q, r.hi[HALF_DUPLEX_BIT]);
					check("maint", maintMode_q, r.hi[MAINT_BIT]);
					check("line on", lineActive_q, 1'b1);
				end
				default:
				begin
					check("buf pulse", bufSeen - b0, 1);
					check("buf info", lastInfo, {r.dir, r.hi[15:14], r.lo, r.hi[13:0]});
				end
			endcase
		end
		// Resume with a slow memory: copy of the table, no start-up
		clearPort(1'b0);
		slow <= 1'b1;
		s0 = startupSeen;
		c0 = readCount;
		cmd('{CMD_TABLE, 1'b0, 1'b0, 16'h0400, 16'h1000}, ok);
		waitCount(readCount, c0 + COPY_WORDS);
		check("copy words", readCount - c0, COPY_WORDS);
		check("resumed", resumed_q, 1'b1);
		check("no startup", startupSeen - s0, 0);
		// Procedure errors: bad code, control first, buffer before control, table twice
		for (int k = 0; k < 4; k++)
		begin
			clearPort(k[0]);
			slow <= k[0];
			if (k >= 2)
				cmd(rows[0], ok);
			// Last case brings the line up first, so the error must take it down
			if (k == 3)
				cmd(rows[1], ok);
			r = rows[k == 0 ? 0 : k == 1 ? 1 : k == 2 ? 2 : 0];
			if (k == 0)
				r.code = 2'h2;
			c0 = writeCount;
			cmd(r, ok);
			waitCount(writeCount, c0 + DUMP_WORDS);
			check("proc error", procError_q, 1'b1);
			check("error code", errorCode_q, PROC_ERR_CODE);
			check("dump words", writeCount - c0, DUMP_WORDS);
			check("dump end", lastWriteAddr, DUMP_BASE + 18'h000fe);
			// Word 0 still holds the first word of the resumed table copy
			check("dump data", word0Data, 16'h0400 ^ 16'h5a5a);
			check("line dead", lineActive_q, 1'b0);
		end
		cmd(rows[1], ok);
		check("halted", ok, 1'b0);
		reportAndStop();
	end
endmodule
`default_nettype wire
